// File: design/misrc_pkg.sv
/*
 * constants, types and decode functions for the coded-input sync and
 * request-rate controller.
 * assumes a single 100 MHz system clock and a layer II bit-rate index.
 */
`default_nettype none
package misrc_pkg;
	// system clock rate in kHz, the unit in which the crystal-mode divider counts
	localparam int SYS_CLK_KHZ = 100000;
	// apb register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// control field positions
	localparam int CTRL_INSEL_LO = 0;
	localparam int CTRL_INSEL_HI = 1;
	localparam int CTRL_MDIS = 2;
	localparam int CTRL_SEN = 3;
	// sticky status flag positions, write one to clear
	localparam int STAT_FREE_REJ = 9;
	localparam int STAT_OVERRUN = 10;
	// reset values, highest and free-format rate indices
	localparam logic [1:0] INSEL_RESET = 2'h0;
	localparam logic [3:0] RATE_IDX_RESET = 4'hE;
	localparam logic [3:0] RATE_IDX_MAX = 4'hE;
	localparam logic [3:0] RATE_IDX_FREE = 4'h0;
	// sample rate selections
	localparam logic [1:0] FS_44K1 = 2'h0;
	localparam logic [1:0] FS_48K = 2'h1;
	localparam logic [1:0] FS_32K = 2'h2;
	// assumed sample rate in 100 Hz units when timed by the sample-rate clock
	localparam int FS_ASSUMED_X100 = 441;
	localparam int RATIO_LOW = 256;
	localparam int RATIO_HIGH = 384;
	// longest layer II frame in bits, the most a search may skip
	localparam int MAX_FRAME_BITS = 13824;
	// cycles after reset release before straps are captured
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	// last bit-clock count of a word-select half period (32 bit clocks)
	localparam logic [4:0] WS_SCK_LAST = 5'h1F;

	typedef enum logic [1:0] {
		SYNC_SEARCH = 2'b00,
		SYNC_VERIFY = 2'b01,
		SYNC_LOCKED = 2'b10
	} misrc_sync_t;

	// layer II bit rate in kbit/s, zero for free format and the forbidden index
	function automatic logic [8:0] misrcKbps(input logic [3:0] idx);
		logic [8:0] k;
		k = 9'h000;
		case (idx)
			4'h1: k = 9'd32;
			4'h2: k = 9'd48;
			4'h3: k = 9'd56;
			4'h4: k = 9'd64;
			4'h5: k = 9'd80;
			4'h6: k = 9'd96;
			4'h7: k = 9'd112;
			4'h8: k = 9'd128;
			4'h9: k = 9'd160;
			4'hA: k = 9'd192;
			4'hB: k = 9'd224;
			4'hC: k = 9'd256;
			4'hD: k = 9'd320;
			4'hE: k = 9'd384;
			default: k = 9'h000;
		endcase
		return k;
	endfunction: misrcKbps

	// muted verification frames needed before output is released
	function automatic logic [1:0] misrcMutedFrames(input logic freeFmt, input logic crc);
		return freeFmt ? (crc ? 2'h1 : 2'h2) : (crc ? 2'h0 : 2'h1);
	endfunction: misrcMutedFrames

	// source edges per half bit-clock period (bit clock is 64 fs)
	function automatic logic [2:0] misrcSckHalf(input logic m0, input logic [1:0] fs,
		input logic ratio);
		if (m0)
			return (fs == FS_32K) ? 3'h6 : 3'h4;
		return ratio ? 3'h3 : 3'h2;
	endfunction: misrcSckHalf
endpackage: misrc_pkg
`default_nettype wire

// File: design/misrc_pin_sync.sv
/*
 * two-flop synchronisers with a rising-edge pulse for asynchronous pins.
 * assumes pins change no faster than half the system clock rate.
 */
`timescale 1ns/10ps
`default_nettype none
module misrc_pin_sync
	import misrc_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta_r;
	logic [W-1:0] level_r;
	logic [W-1:0] prev_r;

	////////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : gBit
			// first flop feeds only the second; edges use the settled copy
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					meta_r[i] <= 1'b0;
					level_r[i] <= 1'b0;
					prev_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= pinIn[i];
					level_r[i] <= meta_r[i];
					prev_r[i] <= level_r[i];
				end
			end
		end
	endgenerate

	// outputs
	assign level = level_r;
	assign rise = level_r & ~prev_r;
endmodule: misrc_pin_sync
`default_nettype wire

// File: design/misrc_rate_div.sv
/*
 * fractional request-rate divider: adds a step on each tick and emits a
 * one-cycle pulse each time the sum passes the limit.
 * assumes step is below limit and that reload clears the phase.
 */
`timescale 1ns/10ps
`default_nettype none
module misrc_rate_div
	import misrc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic reload,
	input wire logic tick,
	input wire logic [11:0] step,
	input wire logic [17:0] limit,
	output logic pulse
);
	logic [17:0] acc_r;
	logic [17:0] acc_nxt;
	logic pulse_r;
	logic pulse_nxt;
	logic [18:0] sum;

	////////////////////////////////////////////////////////////////////////////
	// accumulate; remainder is kept so the average rate is exact
	always_comb
	begin
		sum = {1'b0, acc_r} + {7'h00, step};
		acc_nxt = acc_r;
		pulse_nxt = 1'b0;
		if (!run || reload)
			acc_nxt = 18'h00000;
		else if (tick)
		begin
			if (sum >= {1'b0, limit})
			begin
				acc_nxt = 18'(sum - {1'b0, limit});
				pulse_nxt = 1'b1;
			end
			else
				acc_nxt = sum[17:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_r <= 18'h00000;
			pulse_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign pulse = pulse_r;
endmodule: misrc_rate_div
`default_nettype wire

// File: design/misrc_top.sv
/*
 * clock outputs, frame sync acquisition and master-input request rate for
 * a layer I/II audio decoder, with control over an apb slave.
 * assumes clock and strap pins are asynchronous and the frame parser runs
 * on sys_clk and supplies detect, false, frame-done and header fields.
 */
`timescale 1ns/10ps
`default_nettype none
module misrc_top
	import misrc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic masterClockIn,
	input wire logic crystal44k1ClockIn,
	input wire logic sampleRateClockIn,
	input wire logic masterClockFreqSelect,
	input wire logic sampleClockRatioSelect,
	input wire logic sampleClockSourceSelect,
	input wire logic stopDecode,
	input wire logic unreliableData,
	input wire logic codedBitStrobe,
	input wire logic syncDetect,
	input wire logic syncFalse,
	input wire logic frameDone,
	input wire logic freeFormat,
	input wire logic crcActive,
	input wire logic [3:0] decodedRateIdx,
	input wire logic [1:0] decodedFsIdx,
	output logic masterClockOut,
	output logic masterClockOutOeN,
	output logic sampleRateClockOut,
	output logic sampleRateClockOutOeN,
	output logic i2sSck,
	output logic i2sWs,
	output logic masterDataRequest,
	output logic subbandMute,
	output logic basebandMute,
	output logic strapError
);
	logic [7:0] pinLvl, pinRise;
	logic [1:0] inputSel_r, inputSel_nxt;
	logic mclkDis_r, mclkDis_nxt, sclkEn_r, sclkEn_nxt;
	logic [1:0] flags_r, flags_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [1:0] strapCnt_r, strapCnt_nxt;
	logic freqSel_r, freqSel_nxt, ratioSel_r, ratioSel_nxt, srcSel_r, srcSel_nxt;
	misrc_sync_t state_r, state_nxt;
	logic [1:0] frameCnt_r, frameCnt_nxt, need_r, need_nxt;
	logic [13:0] searchBits_r, searchBits_nxt;
	logic seenData_r, seenData_nxt, masterPrev_r;
	logic [3:0] rateIdx_r, rateIdx_nxt;
	logic [1:0] fsSel_r, fsSel_nxt;
	logic reload_r;
	logic [2:0] sckCnt_r, sckCnt_nxt;
	logic [4:0] wsCnt_r, wsCnt_nxt;
	logic sck_r, sck_nxt, ws_r, ws_nxt;
	logic [1:0] genCnt_r, genCnt_nxt;
	logic genAlt_r, genAlt_nxt, gen_r, gen_nxt, mOut_r, sOut_r;
	logic apbWr, apbAcc, addrHit, masterSel, m0, stopLvl, lossNow, lockNow;
	logic freeHit, overrunHit, rateOk, srcEdge, reqPulse;
	logic [1:0] genLim;
	logic [8:0] kbps;

	////////////////////////////////////////////////////////////////////////////
	// pins from outside the clock domain pass two flops first
	misrc_pin_sync #(.W(8)) uPins (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pinIn({unreliableData, stopDecode, sampleClockSourceSelect,
			sampleClockRatioSelect, masterClockFreqSelect, sampleRateClockIn,
			crystal44k1ClockIn, masterClockIn}),
		.level(pinLvl),
		.rise(pinRise)
	);

	assign masterSel = ~inputSel_r[CTRL_INSEL_HI];
	assign m0 = masterSel & ~srcSel_r;
	assign stopLvl = pinLvl[6];

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, read data registered in the setup cycle
	assign apbAcc = psel & penable;
	assign apbWr = apbAcc & pwrite;
	assign addrHit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
	assign pready = 1'b1;
	assign pslverr = apbAcc & ~addrHit;
	assign prdata = prdata_r;

	always_comb
	begin
		inputSel_nxt = inputSel_r;
		mclkDis_nxt = mclkDis_r;
		sclkEn_nxt = sclkEn_r;
		flags_nxt = flags_r;
		prdata_nxt = prdata_r;
		if (apbWr && paddr == ADDR_CTRL)
		begin
			inputSel_nxt = pwdata[CTRL_INSEL_HI:CTRL_INSEL_LO];
			mclkDis_nxt = pwdata[CTRL_MDIS];
			sclkEn_nxt = pwdata[CTRL_SEN];
		end
		if (apbWr && paddr == ADDR_STATUS)
			flags_nxt = flags_r & ~pwdata[STAT_OVERRUN:STAT_FREE_REJ];
		// a new event in the clear cycle survives
		flags_nxt = flags_nxt | {overrunHit, freeHit};
		if (psel && !penable)
		begin
			if (paddr == ADDR_CTRL)
				prdata_nxt = {28'h0000000, sclkEn_r, mclkDis_r, inputSel_r};
			else if (paddr == ADDR_STATUS)
				prdata_nxt = {21'h000000, flags_r, strapError, fsSel_r, rateIdx_r, state_r};
			else
				prdata_nxt = 32'h00000000;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			inputSel_r <= INSEL_RESET;
			mclkDis_r <= 1'b0;
			sclkEn_r <= 1'b0;
			flags_r <= 2'h0;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			inputSel_r <= inputSel_nxt;
			mclkDis_r <= mclkDis_nxt;
			sclkEn_r <= sclkEn_nxt;
			flags_r <= flags_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// straps are caught once the synchronisers have settled after release
	always_comb
	begin
		strapCnt_nxt = strapCnt_r;
		freqSel_nxt = freqSel_r;
		ratioSel_nxt = ratioSel_r;
		srcSel_nxt = srcSel_r;
		if (strapCnt_r != STRAP_SETTLE)
		begin
			strapCnt_nxt = 2'(strapCnt_r + 2'h1);
			freqSel_nxt = pinLvl[3];
			ratioSel_nxt = pinLvl[4];
			srcSel_nxt = pinLvl[5];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strapCnt_r <= 2'h0;
			freqSel_r <= 1'b1;
			ratioSel_r <= 1'b0;
			srcSel_r <= 1'b0;
		end
		else
		begin
			strapCnt_r <= strapCnt_nxt;
			freqSel_r <= freqSel_nxt;
			ratioSel_r <= ratioSel_nxt;
			srcSel_r <= srcSel_nxt;
		end
	end

	// crystal master mode needs the fast master clock and the low ratio
	assign strapError = m0 & (~freqSel_r | ratioSel_r);

	////////////////////////////////////////////////////////////////////////////
	// frame sync acquisition; stop, unreliable data or an input swap drop sync
	assign lossNow = stopLvl | pinLvl[7] | (masterSel != masterPrev_r);
	assign lockNow = (state_r == SYNC_VERIFY) && !syncFalse && !lossNow &&
		(frameCnt_r >= need_r);
	assign freeHit = (state_r == SYNC_SEARCH) && seenData_r && syncDetect &&
		masterSel && freeFormat;
	assign overrunHit = (state_r == SYNC_SEARCH) &&
		(searchBits_r == 14'(MAX_FRAME_BITS));

	always_comb
	begin
		state_nxt = state_r;
		frameCnt_nxt = frameCnt_r;
		need_nxt = need_r;
		searchBits_nxt = searchBits_r;
		seenData_nxt = seenData_r | codedBitStrobe;
		if (lossNow)
		begin
			state_nxt = SYNC_SEARCH;
			searchBits_nxt = 14'h0000;
		end
		else
		begin
			unique case (state_r)
				SYNC_SEARCH:
				begin
					// search starts once coded data flows
					if (seenData_r && syncDetect && !freeHit)
					begin
						state_nxt = SYNC_VERIFY;
						frameCnt_nxt = 2'h0;
						need_nxt = misrcMutedFrames(freeFormat, crcActive);
					end
					else if (overrunHit)
						searchBits_nxt = 14'h0000;
					else if (codedBitStrobe)
						searchBits_nxt = 14'(searchBits_r + 14'h0001);
				end
				SYNC_VERIFY:
				begin
					if (syncFalse)
					begin
						state_nxt = SYNC_SEARCH;
						searchBits_nxt = 14'h0000;
					end
					else if (lockNow)
						state_nxt = SYNC_LOCKED;
					else if (frameDone)
						frameCnt_nxt = 2'(frameCnt_r + 2'h1);
				end
				SYNC_LOCKED:
				begin
					if (syncFalse)
					begin
						state_nxt = SYNC_SEARCH;
						searchBits_nxt = 14'h0000;
					end
				end
				default: state_nxt = SYNC_SEARCH;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= SYNC_SEARCH;
			frameCnt_r <= 2'h0;
			need_r <= 2'h0;
			searchBits_r <= 14'h0000;
			seenData_r <= 1'b0;
			masterPrev_r <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			frameCnt_r <= frameCnt_nxt;
			need_r <= need_nxt;
			searchBits_r <= searchBits_nxt;
			seenData_r <= seenData_nxt;
			masterPrev_r <= masterSel;
		end
	end

	// audio stays muted until sync is confirmed
	assign subbandMute = (state_r != SYNC_LOCKED);
	assign basebandMute = (state_r != SYNC_LOCKED);

	////////////////////////////////////////////////////////////////////////////
	// request rate and sample rate only move at lock on the master input;
	// in slave mode both registers simply hold, which is the memory
	assign rateOk = (decodedRateIdx != RATE_IDX_FREE) && (decodedRateIdx <= RATE_IDX_MAX);

	always_comb
	begin
		rateIdx_nxt = rateIdx_r;
		fsSel_nxt = fsSel_r;
		if (lockNow && masterSel && rateOk)
			rateIdx_nxt = decodedRateIdx;
		if (lockNow && m0 && decodedFsIdx != 2'h3)
			fsSel_nxt = decodedFsIdx;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rateIdx_r <= RATE_IDX_RESET;
			fsSel_r <= FS_44K1;
			reload_r <= 1'b1;
		end
		else
		begin
			rateIdx_r <= rateIdx_nxt;
			fsSel_r <= fsSel_nxt;
			reload_r <= (rateIdx_nxt != rateIdx_r);
		end
	end

	// crystal mode counts system cycles; the sample-clock mode counts its edges
	// against an assumed 44.1 kHz, so the real rate scales with that clock
	assign kbps = misrcKbps(rateIdx_r);

	misrc_rate_div uDiv (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.run(masterSel & ~stopLvl),
		.reload(reload_r),
		.tick(srcSel_r ? pinRise[2] : 1'b1),
		.step(srcSel_r ? 12'(kbps * 10) : {3'h0, kbps}),
		.limit(srcSel_r ? (ratioSel_r ? 18'(RATIO_HIGH * FS_ASSUMED_X100) :
			18'(RATIO_LOW * FS_ASSUMED_X100)) : 18'(SYS_CLK_KHZ)),
		.pulse(reqPulse)
	);

	assign masterDataRequest = reqPulse & masterSel & ~stopLvl;

	////////////////////////////////////////////////////////////////////////////
	// i2s clocks and generated 256 fs clock from the selected source edges;
	// outputs are resampled copies, so edges jitter by one system cycle
	assign srcEdge = m0 ? ((fsSel_r == FS_44K1) ? pinRise[1] : pinRise[0]) :
		pinRise[2];
	assign genLim = ((fsSel_r == FS_32K) && genAlt_r) ? 2'h2 : 2'h1;

	always_comb
	begin
		sckCnt_nxt = sckCnt_r;
		sck_nxt = sck_r;
		wsCnt_nxt = wsCnt_r;
		ws_nxt = ws_r;
		genCnt_nxt = genCnt_r;
		genAlt_nxt = genAlt_r;
		gen_nxt = gen_r;
		if (srcEdge)
		begin
			sckCnt_nxt = 3'(sckCnt_r + 3'h1);
			if (sckCnt_nxt >= misrcSckHalf(m0, fsSel_r, ratioSel_r))
			begin
				sckCnt_nxt = 3'h0;
				sck_nxt = ~sck_r;
				// word select moves on the falling bit-clock edge
				if (sck_r)
				begin
					wsCnt_nxt = 5'(wsCnt_r + 5'h01);
					if (wsCnt_r == WS_SCK_LAST)
						ws_nxt = ~ws_r;
				end
			end
			// 768 fs source: alternate one and two edges for 256 fs on average
			genCnt_nxt = 2'(genCnt_r + 2'h1);
			if (genCnt_nxt >= genLim)
			begin
				genCnt_nxt = 2'h0;
				gen_nxt = ~gen_r;
				genAlt_nxt = ~genAlt_r;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sckCnt_r <= 3'h0;
			sck_r <= 1'b0;
			wsCnt_r <= 5'h00;
			ws_r <= 1'b0;
			genCnt_r <= 2'h0;
			genAlt_r <= 1'b0;
			gen_r <= 1'b0;
			mOut_r <= 1'b0;
			sOut_r <= 1'b0;
		end
		else
		begin
			sckCnt_r <= sckCnt_nxt;
			sck_r <= sck_nxt;
			wsCnt_r <= wsCnt_nxt;
			ws_r <= ws_nxt;
			genCnt_r <= genCnt_nxt;
			genAlt_r <= genAlt_nxt;
			gen_r <= gen_nxt;
			mOut_r <= pinLvl[0];
			sOut_r <= m0 ? gen_r : pinLvl[2];
		end
	end

	assign i2sSck = sck_r;
	assign i2sWs = ws_r;
	assign masterClockOut = mOut_r;
	assign masterClockOutOeN = mclkDis_r;
	assign sampleRateClockOut = sOut_r;
	assign sampleRateClockOutOeN = ~sclkEn_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	mclk_oe_ctrl_a: assert property (apbWr && paddr == ADDR_CTRL |=> masterClockOutOeN == $past(pwdata[CTRL_MDIS])) else $error("master clock enable not following control");
	sclk_oe_ctrl_a: assert property (apbWr && paddr == ADDR_CTRL |=> sampleRateClockOutOeN != $past(pwdata[CTRL_SEN])) else $error("sample clock enable not following control");
	reset_out_a: assert property (!$past(rstn) |-> !masterClockOutOeN && sampleRateClockOutOeN) else $error("clock outputs wrong after reset");
	mute_unlocked_a: assert property ($fell(subbandMute) || $fell(basebandMute) |-> $past(state_r) == SYNC_VERIFY && subbandMute == basebandMute) else $error("audio unmuted outside verification");
	false_sync_a: assert property (state_r == SYNC_VERIFY && syncFalse |=> state_r == SYNC_SEARCH) else $error("false sync did not restart search");
	lock_frames_a: assert property ($rose(state_r == SYNC_LOCKED) |-> $past(frameCnt_r) >= $past(need_r)) else $error("locked before muted frames");
	req_halt_a: assert property (stopLvl || !masterSel |=> !reqPulse && !masterDataRequest) else $error("request while halted");
	rate_hold_a: assert property (!lockNow |=> rateIdx_r == $past(rateIdx_r)) else $error("request rate changed outside lock");
	rate_adopt_a: assert property (lockNow && masterSel && rateOk |=> rateIdx_r == $past(decodedRateIdx) && (reload_r || rateIdx_r == $past(rateIdx_r))) else $error("decoded rate not adopted");
endmodule: misrc_top
`default_nettype wire

// File: testbench/misrc_coded_source.sv
/*
 * model of the coded bitstream source on the master input, with its buffer.
 * assumes requests are one-cycle pulses on sys_clk and data is always ready.
 */
`timescale 1ns/10ps
`default_nettype none
module misrc_coded_source
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic dataRequest,
	output logic codedBitStrobe
);
	logic strobe_r;
	logic strobe_nxt;
	////////////////////////////////////////////////////////////////////////////////
	// buffer never runs dry, so every request is answered on the next edge
	always_comb
	begin
		strobe_nxt = dataRequest;
	end
	// headers carry a standard or free-format bit-rate index, set by the bench's parser stand-in
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			strobe_r <= 1'b0;
		else
			strobe_r <= strobe_nxt;
	end
	assign codedBitStrobe = strobe_r;
endmodule: misrc_coded_source
`default_nettype wire

// File: testbench/mpeg_input_sync_rate_control_tb.sv
/*
 * bench for the sync and request-rate controller, crystal-clock master setup.
 * assumes misrc_pkg and the coded source model are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
module mpeg_input_sync_rate_control_tb
	import misrc_pkg::*;
;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err, mcIn, stopDecode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic strobe, det, fls, done, free, crc, mcOut, mcOeN, fsOut, fsOeN, req;
	logic sbMute, bbMute, strapError;
	logic xIn, urda, sck, ws;
	logic [3:0] idx, hist;
	logic [1:0] mcDiv;
	int n_mismatch, check_count, c;
	misrc_top DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .masterClockIn(mcIn), .crystal44k1ClockIn(xIn),
		.sampleRateClockIn(1'b0),
		.masterClockFreqSelect(1'b1), .sampleClockRatioSelect(1'b0),
		.sampleClockSourceSelect(1'b0), .stopDecode(stopDecode), .unreliableData(urda),
		.codedBitStrobe(strobe), .syncDetect(det), .syncFalse(fls), .frameDone(done),
		.freeFormat(free), .crcActive(crc), .decodedRateIdx(idx), .decodedFsIdx(2'h0),
		.masterClockOut(mcOut), .masterClockOutOeN(mcOeN), .sampleRateClockOut(fsOut),
		.sampleRateClockOutOeN(fsOeN), .i2sSck(sck), .i2sWs(ws), .masterDataRequest(req),
		.subbandMute(sbMute), .basebandMute(bbMute), .strapError(strapError));
	misrc_coded_source src (.sys_clk(sys_clk), .rstn(rstn), .dataRequest(req),
		.codedBitStrobe(strobe));
	////////////////////////////////////////////////////////////////////////////////
	// master clock pin, with a history to compare the buffered copy against
	always @(posedge sys_clk)
	begin
		mcDiv <= mcDiv + 2'h1;
		if (mcDiv == 2'h3)
			mcIn <= ~mcIn;
		// crystal stand-in: one rising edge every four system cycles
		if (mcDiv[0])
			xIn <= ~xIn;
		hist <= {hist[2:0], mcIn};
	end
	// free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask: chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask: apb
	// one header event from the parser stand-in; pulses last one cycle
	task hdr(input logic d, input logic f, input logic n, input logic ff, input logic cr,
		input logic [3:0] ix);
		@(posedge sys_clk);
		det <= d;
		fls <= f;
		done <= n;
		free <= ff;
		crc <= cr;
		idx <= ix;
		@(posedge sys_clk);
		det <= 1'b0;
		fls <= 1'b0;
		done <= 1'b0;
	endtask: hdr
	task cnt(input int n);
		c = 0;
		repeat (n)
		begin
			@(negedge sys_clk);
			if (req === 1'b1)
				c++;
		end
	endtask: cnt
	task complete_run;
		$display("compares %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask: complete_run
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_reset;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		// straps are caught on the third edge after release; look once it has settled
		@(negedge sys_clk);
		chk({mcOeN, fsOeN}, 2'h1);
		chk({sbMute, bbMute, strapError}, 3'h6);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[5:0], {4'hE, 2'h0});
		apb(1'b0, 8'h08, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask: t_reset
	task t_clkout;
		repeat (24)
		begin
			@(negedge sys_clk);
			if (hist[3] == hist[1] && hist[2] == hist[1])
				chk(mcOut, hist[2]);
		end
		apb(1'b1, ADDR_CTRL, 32'hC);
		@(negedge sys_clk);
		chk({mcOeN, fsOeN}, 2'h2);
		apb(1'b1, ADDR_CTRL, 32'h0);
	endtask: t_clkout
	// crystal master: 512 fs source gives 256 fs out, 64 fs bit clock, ws every 32 sck
	task t_clkgen;
		logic pf, ps, pw;
		int nf, ns, nw;
		pf = fsOut;
		ps = sck;
		pw = ws;
		nf = 0;
		ns = 0;
		nw = 0;
		repeat (2048)
		begin
			@(negedge sys_clk);
			if (fsOut === 1'b1 && pf === 1'b0)
				nf++;
			if (sck === 1'b1 && ps === 1'b0)
				ns++;
			if (ws !== pw)
				nw++;
			pf = fsOut;
			ps = sck;
			pw = ws;
		end
		chk(nf >= 255 && nf <= 257, 1);
		chk(ns >= 63 && ns <= 65, 1);
		chk(nw >= 1 && nw <= 3, 1);
	endtask: t_clkgen
	task t_sync;
		cnt(2604);
		chk(c >= 9 && c <= 11, 1);
		hdr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'hA);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({sbMute, rd[1:0]}, 3'h5);
		hdr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hA);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({sbMute, bbMute, rd[5:0]}, {2'h0, 4'hA, 2'h2});
		cnt(2083);
		chk(c >= 3 && c <= 5, 1);
		hdr(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hA);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({sbMute, rd[5:0]}, {1'b1, 4'hA, 2'h0});
		hdr(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h8);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(sbMute, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[5:0], {4'h8, 2'h2});
		// unreliable data drops the lock; mute must return
		@(posedge sys_clk);
		urda <= 1'b1;
		repeat (4) @(posedge sys_clk);
		urda <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(sbMute, 1'b1);
		hdr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({rd[9], rd[5:0]}, {1'b1, 4'h8, 2'h0});
		apb(1'b1, ADDR_STATUS, 32'h200);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[9], 1'b0);
	endtask: t_sync
	task t_stop;
		@(posedge sys_clk);
		stopDecode <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cnt(1600);
		chk(c, 0);
		@(posedge sys_clk);
		stopDecode <= 1'b0;
		cnt(1600);
		chk(c >= 1 && c <= 3, 1);
		apb(1'b1, ADDR_CTRL, 32'h2);
		cnt(1600);
		chk(c, 0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		cnt(1600);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({c >= 1 && c <= 3, rd[5:2]}, {1'b1, 4'h8});
	endtask: t_stop
	////////////////////////////////////////////////////////////////////////////////
	// main sequence and hang watchdog
	initial
	begin
		{rstn, psel, penable, pwrite, paddr, pwdata, mcIn, stopDecode} = '0;
		{det, fls, done, free, crc, idx, hist, mcDiv, xIn, urda} = '0;
		n_mismatch = 0;
		check_count = 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_clkout();
		t_clkgen();
		t_sync();
		t_stop();
		complete_run();
	end
	initial
	begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch++;
		complete_run();
	end
endmodule: mpeg_input_sync_rate_control_tb
`default_nettype wire
